// *** core/ldev_decode.sv ***
// logical device i/o decode, config index/data ports, irq/dma gating
// assumes a host cycle front end delivering one-cycle i/o strobes on CLK
// Functional notes
// - after reset the config port pair sits at 0x02E for strap 0 and 0x04E for strap 1.
// - writing config indices 0x12 and 0x13 moves the config port base to any 2-byte step in 0x0000..0xFFFE, with no range check.
// - the host writes an index to the config base and reads or writes that register at base plus one.
// - the runtime block decodes 16 bytes at the base from index runtime_block_base_address, valid 0x0100..0x0FF0 on 16-byte steps.
// - the parallel base from index parallel_base_address may be any 4-byte step in 0x0100..0x03FC, and without 8-byte alignment EPP is off.
// - with an 8-byte aligned parallel base the EPP registers at +3..+7 decode; the ECP registers at +400h..+402h decode at any valid parallel base.
// - a block's own disable bit suppresses its irq or dma request, except the parallel irq enable in FIFO, ECP and test modes.
// - a block's irq and dma are also suppressed when it is inactive or its base is invalid.
// - floppy digital output bit 3 low disables floppy irq and dma.
// - a powered down floppy controller keeps its irq and dma disabled.
// - a serial port's modem control bit 2 low disables that port's interrupt.
// - clearing the infrared port dma enable disables its dma.
// - in standard and EPP modes parallel control bit 4 low disables the parallel interrupt.
// - in every extended control mode the parallel dma is gated only by its dma enable bit.
// - extended modes FIFO, ECP and test keep the parallel irq on, the others gate it by the irq enable bit.
`include "ldev_decode_params.svh"

module ldev_decode (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CONFIG_ADDRESS_STRAP,
    input  wire logic [15:0] IO_ADDR,
    input  wire logic        IO_WR,
    input  wire logic        IO_RD,
    input  wire logic [7:0]  IO_WDATA,
    output logic      [7:0]  IO_RDATA,
    output logic             IO_CLAIM,
    output logic             CFG_SEL,
    output logic             FLOPPY_SEL,
    output logic             PARALLEL_SEL,
    output logic             PARALLEL_EPP_SEL,
    output logic             PARALLEL_ECP_SEL,
    output logic             SERIAL1_SEL,
    output logic             SERIAL2_SEL,
    output logic             INFRARED_SEL,
    output logic             RUNTIME_SEL,
    output logic             PARALLEL_EPP_AVAILABLE,
    input  wire logic        FLOPPY_ACTIVE,
    input  wire logic        PARALLEL_ACTIVE,
    input  wire logic        SERIAL1_ACTIVE,
    input  wire logic        SERIAL2_ACTIVE,
    input  wire logic        INFRARED_ACTIVE,
    input  wire logic        RUNTIME_ACTIVE,
    input  wire logic        FLOPPY_DMA_IRQ_ENABLE,
    input  wire logic        FLOPPY_POWERED_DOWN,
    input  wire logic        SERIAL1_IRQ_GATE,
    input  wire logic        SERIAL2_IRQ_GATE,
    input  wire logic        INFRARED_DMA_ENABLE,
    input  wire logic        PARALLEL_IRQ_ENABLE,
    input  wire logic        PARALLEL_DMA_ENABLE,
    input  wire logic [2:0]  PARALLEL_ECR_MODE,
    input  wire logic        FLOPPY_IRQ_IN,
    input  wire logic        FLOPPY_DRQ_IN,
    input  wire logic        PARALLEL_IRQ_IN,
    input  wire logic        PARALLEL_DRQ_IN,
    input  wire logic        SERIAL1_IRQ_IN,
    input  wire logic        SERIAL2_IRQ_IN,
    input  wire logic        INFRARED_IRQ_IN,
    input  wire logic        INFRARED_DRQ_IN,
    output logic             FLOPPY_IRQ,
    output logic             FLOPPY_DRQ,
    output logic             PARALLEL_IRQ,
    output logic             PARALLEL_DRQ,
    output logic             SERIAL1_IRQ,
    output logic             SERIAL2_IRQ,
    output logic             INFRARED_IRQ,
    output logic             INFRARED_DRQ
);

    // base register byte back to a byte address
    function automatic ldev_decode_pkg::io_addr_t base_of(input logic [7:0] value, input int shift);
        ldev_decode_pkg::io_addr_t wide;
        wide = {8'h00, value};
        return ldev_decode_pkg::io_addr_t'(wide << shift);
    endfunction

    function automatic logic base_ok(input ldev_decode_pkg::io_addr_t base,
                                     input ldev_decode_pkg::io_addr_t hi,
                                     input int                        align_log2);
        ldev_decode_pkg::io_addr_t mask;
        mask = ldev_decode_pkg::io_addr_t'((32'h1 << align_log2) - 32'h1);
        return (base >= `LEGACY_MIN) && (base <= hi) && ((base & mask) == 16'h0000);
    endfunction

    function automatic logic in_span(input ldev_decode_pkg::io_addr_t addr,
                                     input ldev_decode_pkg::io_addr_t base,
                                     input int                        span_log2);
        return (addr >> span_log2) == (base >> span_log2);
    endfunction

    logic [7:0] cfg_index_reg;
    logic [7:0] config_port_base_reg_a;
    logic [7:0] config_port_base_reg_b;
    logic [7:0] floppy_base_address;
    logic [7:0] parallel_base_address;
    logic [7:0] serial1_base_address;
    logic [7:0] serial2_base_address;
    logic [7:0] infrared_base_address;
    logic [7:0] runtime_block_base_address;
    logic       strap_taken_reg;

    ldev_decode_pkg::io_addr_t cfg_base;
    ldev_decode_pkg::io_addr_t floppy_base;
    ldev_decode_pkg::io_addr_t parallel_base;
    ldev_decode_pkg::io_addr_t serial1_base;
    ldev_decode_pkg::io_addr_t serial2_base;
    ldev_decode_pkg::io_addr_t infrared_base;
    ldev_decode_pkg::io_addr_t runtime_base;
    ldev_decode_pkg::io_addr_t par_rel;

    logic floppy_ok;
    logic parallel_ok;
    logic parallel_epp_ok;
    logic serial1_ok;
    logic serial2_ok;
    logic infrared_ok;
    logic runtime_ok;
    logic cfg_index_hit;
    logic cfg_data_hit;
    logic [7:0] cfg_read_value;
    logic par_irq_forced;

    // bit 0 ignored keeps the pair on a 2-byte step
    assign cfg_base = {config_port_base_reg_b, config_port_base_reg_a[7:1], 1'b0};
    assign floppy_base   = base_of(floppy_base_address, `SHIFT_LEGACY);
    assign parallel_base = base_of(parallel_base_address, `SHIFT_LEGACY);
    assign serial1_base  = base_of(serial1_base_address, `SHIFT_LEGACY);
    assign serial2_base  = base_of(serial2_base_address, `SHIFT_LEGACY);
    assign infrared_base = base_of(infrared_base_address, `SHIFT_INFRARED);
    assign runtime_base  = base_of(runtime_block_base_address, `SHIFT_RUNTIME);

    assign floppy_ok       = base_ok(floppy_base, `LEGACY_MAX8, `SPAN_LOG2_EIGHT);
    assign serial1_ok      = base_ok(serial1_base, `LEGACY_MAX8, `SPAN_LOG2_EIGHT);
    assign serial2_ok      = base_ok(serial2_base, `LEGACY_MAX8, `SPAN_LOG2_EIGHT);
    assign infrared_ok     = base_ok(infrared_base, `INFRARED_MAX, `SPAN_LOG2_EIGHT);
    assign runtime_ok      = base_ok(runtime_base, `RUNTIME_MAX, `SPAN_LOG2_SIXTEEN);
    assign parallel_ok     = base_ok(parallel_base, `LEGACY_MAX4, `SPAN_LOG2_FOUR);
    assign parallel_epp_ok = base_ok(parallel_base, `LEGACY_MAX8, `SPAN_LOG2_EIGHT);
    assign PARALLEL_EPP_AVAILABLE = parallel_ok && parallel_epp_ok;

    // no decode until the strap has been taken
    assign cfg_index_hit = strap_taken_reg && (IO_ADDR == cfg_base);
    assign cfg_data_hit  = strap_taken_reg && (IO_ADDR == (cfg_base + `CFG_DATA_OFFSET));
    assign CFG_SEL       = cfg_index_hit || cfg_data_hit;

    assign par_rel = IO_ADDR - parallel_base;

    always_comb begin
        FLOPPY_SEL       = FLOPPY_ACTIVE && floppy_ok && in_span(IO_ADDR, floppy_base, `SPAN_LOG2_EIGHT);
        SERIAL1_SEL      = SERIAL1_ACTIVE && serial1_ok && in_span(IO_ADDR, serial1_base, `SPAN_LOG2_EIGHT);
        SERIAL2_SEL      = SERIAL2_ACTIVE && serial2_ok && in_span(IO_ADDR, serial2_base, `SPAN_LOG2_EIGHT);
        INFRARED_SEL     = INFRARED_ACTIVE && infrared_ok && in_span(IO_ADDR, infrared_base, `SPAN_LOG2_EIGHT);
        RUNTIME_SEL      = RUNTIME_ACTIVE && runtime_ok && in_span(IO_ADDR, runtime_base, `SPAN_LOG2_SIXTEEN);
        PARALLEL_EPP_SEL = PARALLEL_ACTIVE && PARALLEL_EPP_AVAILABLE
                           && (par_rel >= `PAR_EPP_FIRST) && (par_rel <= `PAR_EPP_LAST);
        PARALLEL_ECP_SEL = PARALLEL_ACTIVE && parallel_ok
                           && (par_rel >= `PAR_ECP_FIRST) && (par_rel <= `PAR_ECP_LAST);
        PARALLEL_SEL     = (PARALLEL_ACTIVE && parallel_ok && in_span(IO_ADDR, parallel_base, `SPAN_LOG2_FOUR))
                           || PARALLEL_EPP_SEL || PARALLEL_ECP_SEL;
    end

    // anything outside these windows is left to other agents
    assign IO_CLAIM = (IO_WR || IO_RD) && (CFG_SEL || FLOPPY_SEL || PARALLEL_SEL || SERIAL1_SEL
                                          || SERIAL2_SEL || INFRARED_SEL || RUNTIME_SEL);

    // strap can only be sampled once the clock runs after release
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_taken_reg <= 1'b0;
        end else begin
            strap_taken_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_index_reg <= `RESET_BYTE;
        end else if (IO_WR && cfg_index_hit) begin
            cfg_index_reg <= IO_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            config_port_base_reg_a <= `RESET_BYTE;
            config_port_base_reg_b <= `RESET_BYTE;
        end else if (!strap_taken_reg) begin
            {config_port_base_reg_b, config_port_base_reg_a} <= CONFIG_ADDRESS_STRAP ? `CFG_BASE_STRAP1
                                                                                      : `CFG_BASE_STRAP0;
        end else if (IO_WR && cfg_data_hit) begin
            if (cfg_index_reg == `IDX_CFG_BASE_LO) begin
                config_port_base_reg_a <= IO_WDATA;
            end
            if (cfg_index_reg == `IDX_CFG_BASE_HI) begin
                config_port_base_reg_b <= IO_WDATA;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            floppy_base_address        <= `RESET_BYTE;
            parallel_base_address      <= `RESET_BYTE;
            serial1_base_address       <= `RESET_BYTE;
            serial2_base_address       <= `RESET_BYTE;
            infrared_base_address      <= `RESET_BYTE;
            runtime_block_base_address <= `RESET_BYTE;
        end else if (IO_WR && cfg_data_hit) begin
            unique case (cfg_index_reg)
                `IDX_FLOPPY_BASE:   floppy_base_address        <= IO_WDATA;
                `IDX_PARALLEL_BASE: parallel_base_address      <= IO_WDATA;
                `IDX_SERIAL1_BASE:  serial1_base_address       <= IO_WDATA;
                `IDX_SERIAL2_BASE:  serial2_base_address       <= IO_WDATA;
                `IDX_INFRARED_BASE: infrared_base_address      <= IO_WDATA;
                `IDX_RUNTIME_BASE:  runtime_block_base_address <= IO_WDATA;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        unique case (cfg_index_reg)
            `IDX_CFG_BASE_LO:   cfg_read_value = config_port_base_reg_a;
            `IDX_CFG_BASE_HI:   cfg_read_value = config_port_base_reg_b;
            `IDX_FLOPPY_BASE:   cfg_read_value = floppy_base_address;
            `IDX_PARALLEL_BASE: cfg_read_value = parallel_base_address;
            `IDX_SERIAL1_BASE:  cfg_read_value = serial1_base_address;
            `IDX_SERIAL2_BASE:  cfg_read_value = serial2_base_address;
            `IDX_INFRARED_BASE: cfg_read_value = infrared_base_address;
            `IDX_RUNTIME_BASE:  cfg_read_value = runtime_block_base_address;
            default:            cfg_read_value = `RESET_BYTE;
        endcase
    end

    // read data is held until the next config read
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            IO_RDATA <= `RESET_BYTE;
        end else if (IO_RD && cfg_index_hit) begin
            IO_RDATA <= cfg_index_reg;
        end else if (IO_RD && cfg_data_hit) begin
            IO_RDATA <= cfg_read_value;
        end
    end

    always_comb begin
        unique case (ldev_decode_pkg::ecr_mode_t'(PARALLEL_ECR_MODE))
            ldev_decode_pkg::ECR_FIFO,
            ldev_decode_pkg::ECR_ECP,
            ldev_decode_pkg::ECR_TEST: par_irq_forced = 1'b1;
            default:                   par_irq_forced = 1'b0;
        endcase
    end

    // one cycle of latency on every request, traded for glitch-free outputs
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            FLOPPY_IRQ <= 1'b0;
            FLOPPY_DRQ <= 1'b0;
        end else begin
            FLOPPY_IRQ <= FLOPPY_IRQ_IN && FLOPPY_ACTIVE && floppy_ok
                          && FLOPPY_DMA_IRQ_ENABLE && !FLOPPY_POWERED_DOWN;
            FLOPPY_DRQ <= FLOPPY_DRQ_IN && FLOPPY_ACTIVE && floppy_ok
                          && FLOPPY_DMA_IRQ_ENABLE && !FLOPPY_POWERED_DOWN;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SERIAL1_IRQ <= 1'b0;
            SERIAL2_IRQ <= 1'b0;
        end else begin
            SERIAL1_IRQ <= SERIAL1_IRQ_IN && SERIAL1_ACTIVE && serial1_ok && SERIAL1_IRQ_GATE;
            SERIAL2_IRQ <= SERIAL2_IRQ_IN && SERIAL2_ACTIVE && serial2_ok && SERIAL2_IRQ_GATE;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            INFRARED_IRQ <= 1'b0;
            INFRARED_DRQ <= 1'b0;
        end else begin
            INFRARED_IRQ <= INFRARED_IRQ_IN && INFRARED_ACTIVE && infrared_ok;
            INFRARED_DRQ <= INFRARED_DRQ_IN && INFRARED_ACTIVE && infrared_ok && INFRARED_DMA_ENABLE;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PARALLEL_IRQ <= 1'b0;
            PARALLEL_DRQ <= 1'b0;
        end else begin
            PARALLEL_IRQ <= PARALLEL_IRQ_IN && PARALLEL_ACTIVE && parallel_ok
                            && (par_irq_forced || PARALLEL_IRQ_ENABLE);
            PARALLEL_DRQ <= PARALLEL_DRQ_IN && PARALLEL_ACTIVE && parallel_ok
                            && PARALLEL_DMA_ENABLE;
        end
    end

endmodule

// *** core/ldev_decode_params.svh ***
// constants for the logical device decoder and irq/dma gating
// assumes a 16-bit host i/o address and byte-wide config registers
`ifndef LDEV_DECODE_PARAMS_SVH
`define LDEV_DECODE_PARAMS_SVH

`define CFG_BASE_STRAP0     16'h002E
`define CFG_BASE_STRAP1     16'h004E
`define CFG_BASE_MIN        16'h0100
`define CFG_BASE_MAX        16'h07FE
`define CFG_DATA_OFFSET     16'h0001

`define IDX_CFG_BASE_LO     8'h12
`define IDX_CFG_BASE_HI     8'h13
`define IDX_FLOPPY_BASE     8'h20
`define IDX_PARALLEL_BASE   8'h23
`define IDX_SERIAL1_BASE    8'h24
`define IDX_SERIAL2_BASE    8'h25
`define IDX_INFRARED_BASE   8'h2B
`define IDX_RUNTIME_BASE    8'h30

`define RESET_BYTE          8'h00
`define LEGACY_MIN          16'h0100
`define LEGACY_MAX4         16'h03FC
`define LEGACY_MAX8         16'h03F8
`define INFRARED_MAX        16'h07F8
`define RUNTIME_MAX         16'h0FF0

`define SHIFT_LEGACY        2
`define SHIFT_INFRARED      3
`define SHIFT_RUNTIME       4
`define SPAN_LOG2_EIGHT     3
`define SPAN_LOG2_FOUR      2
`define SPAN_LOG2_SIXTEEN   4

`define PAR_EPP_FIRST       16'h0003
`define PAR_EPP_LAST        16'h0007
`define PAR_ECP_FIRST       16'h0400
`define PAR_ECP_LAST        16'h0402

`endif

// *** core/ldev_decode_pkg.sv ***
// types shared by the logical device decoder
// assumes nothing beyond the params header
package ldev_decode_pkg;
    typedef enum logic [2:0] {
        ECR_PRINTER = 3'h0,
        ECR_SPP     = 3'h1,
        ECR_FIFO    = 3'h2,
        ECR_ECP     = 3'h3,
        ECR_EPP     = 3'h4,
        ECR_RES     = 3'h5,
        ECR_TEST    = 3'h6,
        ECR_CONFIG  = 3'h7
    } ecr_mode_t;

    typedef logic [15:0] io_addr_t;
endpackage

// *** sim/ldev_decode_asserts.sv ***
// concurrent checks on claim, selects, config read data and gated requests
// assumes a bind onto ldev_decode, one clock CLK, async active-low RST_N
module ldev_decode_asserts (
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic       IO_WR,
    input wire logic       IO_RD,
    input wire logic [7:0] IO_RDATA,
    input wire logic       IO_CLAIM,
    input wire logic       CFG_SEL,
    input wire logic       FLOPPY_SEL,
    input wire logic       PARALLEL_SEL,
    input wire logic       PARALLEL_EPP_SEL,
    input wire logic       SERIAL1_SEL,
    input wire logic       SERIAL2_SEL,
    input wire logic       INFRARED_SEL,
    input wire logic       RUNTIME_SEL,
    input wire logic       PARALLEL_EPP_AVAILABLE,
    input wire logic       PARALLEL_ACTIVE,
    input wire logic       FLOPPY_DMA_IRQ_ENABLE,
    input wire logic       FLOPPY_POWERED_DOWN,
    input wire logic       SERIAL1_IRQ_GATE,
    input wire logic       SERIAL2_IRQ_GATE,
    input wire logic       INFRARED_DMA_ENABLE,
    input wire logic       PARALLEL_IRQ_ENABLE,
    input wire logic       PARALLEL_DMA_ENABLE,
    input wire logic [2:0] PARALLEL_ECR_MODE,
    input wire logic       PARALLEL_IRQ_IN,
    input wire logic       FLOPPY_IRQ,
    input wire logic       FLOPPY_DRQ,
    input wire logic       PARALLEL_IRQ,
    input wire logic       PARALLEL_DRQ,
    input wire logic       SERIAL1_IRQ,
    input wire logic       SERIAL2_IRQ,
    input wire logic       INFRARED_DRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // fifo mode with the control enable low: only the mode keeps the irq alive
    sequence fifo_irq_s;
        PARALLEL_ECR_MODE == 3'h2 && PARALLEL_IRQ_IN && PARALLEL_ACTIVE && !PARALLEL_IRQ_ENABLE
            && PARALLEL_EPP_AVAILABLE;
    endsequence
    AST_FIFO_IRQ: assert property (fifo_irq_s |=> PARALLEL_IRQ)
        else $error("parallel irq not forced on in fifo mode");
    AST_PAR_IRQ: assert property (PARALLEL_IRQ |-> $past(PARALLEL_IRQ_ENABLE) || $past(PARALLEL_ECR_MODE) inside {3'h2, 3'h3, 3'h6})
        else $error("parallel irq passed with its gate closed");
    AST_PAR_DRQ: assert property (PARALLEL_DRQ |-> $past(PARALLEL_DMA_ENABLE) && $past(PARALLEL_ACTIVE))
        else $error("parallel drq passed without dma enable or activation");
    AST_FLOPPY_DOR: assert property (!$past(FLOPPY_DMA_IRQ_ENABLE) |-> !FLOPPY_IRQ && !FLOPPY_DRQ)
        else $error("floppy request passed with dma enable low");
    AST_FLOPPY_PD: assert property (FLOPPY_POWERED_DOWN [*2] |-> !FLOPPY_IRQ && !FLOPPY_DRQ)
        else $error("floppy request passed while powered down");
    AST_SERIAL_GATE: assert property ((!$past(SERIAL1_IRQ_GATE) |-> !SERIAL1_IRQ) and (!$past(SERIAL2_IRQ_GATE) |-> !SERIAL2_IRQ))
        else $error("serial irq passed with modem control gate low");
    AST_IR_DMA: assert property ($fell(INFRARED_DMA_ENABLE) |=> !INFRARED_DRQ)
        else $error("infrared drq passed after dma enable cleared");
    AST_EPP: assert property (PARALLEL_EPP_SEL |-> PARALLEL_EPP_AVAILABLE && PARALLEL_SEL)
        else $error("epp select without 8-byte aligned parallel base");
    AST_CLAIM: assert property (IO_CLAIM |-> (IO_WR || IO_RD) && (CFG_SEL || FLOPPY_SEL || PARALLEL_SEL || SERIAL1_SEL || SERIAL2_SEL || INFRARED_SEL || RUNTIME_SEL))
        else $error("cycle claimed outside every decoded window");
    AST_RDATA: assert property ($changed(IO_RDATA) |-> $past(IO_RD) && $past(CFG_SEL))
        else $error("read data changed without a config port read");
endmodule

// *** sim/lpc_host_model.sv ***
// host model issuing one-cycle i/o strobes to the decoder
// assumes the decoder samples strobes on the rising edge of CLK
module lpc_host_model (
    input  wire logic        CLK,
    input  wire logic [7:0]  IO_RDATA,
    input  wire logic        IO_CLAIM,
    output logic      [15:0] IO_ADDR,
    output logic             IO_WR,
    output logic             IO_RD,
    output logic      [7:0]  IO_WDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    logic claim_seen;
    initial begin
        {IO_ADDR, IO_WR, IO_RD, IO_WDATA} = '0;
        claim_seen = 1'h0;
    end
    // released address and data lines show the inverse and both strobes drop, so a stale value never looks valid
    task automatic cycle(input logic [15:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
        @(negedge CLK);
        {IO_ADDR, IO_WDATA, IO_WR, IO_RD} = {a, d, wr, !wr};
        #1 claim_seen = IO_CLAIM;
        @(negedge CLK);
        {IO_ADDR, IO_WDATA, IO_WR, IO_RD} = {~a, ~d, 2'h0};
        q = IO_RDATA;
    endtask
    task automatic cfg(input logic [15:0] base, input logic [7:0] idx, input logic wr,
                       input logic [7:0] d, output logic [7:0] q);
        cycle(base, 1'h1, idx, q);
        cycle(base + 16'h0001, wr, d, q);
    endtask
    task automatic put_addr(input logic [15:0] a);
        @(negedge CLK);
        IO_ADDR = a;
        #1;
    endtask
endmodule

// *** sim/tb_top.sv ***
// self-checking bench: config port, window decode and request gating
// assumes the host model and checker are compiled before this file
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CLK = 1'h0;
    logic        RST_N, CONFIG_ADDRESS_STRAP, IO_WR, IO_RD, IO_CLAIM, PARALLEL_EPP_AVAILABLE;
    logic [15:0] IO_ADDR, base;
    logic [7:0]  IO_WDATA, IO_RDATA, q;
    logic [2:0]  PARALLEL_ECR_MODE;
    logic        CFG_SEL, FLOPPY_SEL, PARALLEL_SEL, SERIAL1_SEL, SERIAL2_SEL, INFRARED_SEL, RUNTIME_SEL;
    logic        PARALLEL_EPP_SEL, PARALLEL_ECP_SEL;
    logic        FLOPPY_ACTIVE, PARALLEL_ACTIVE, SERIAL1_ACTIVE, SERIAL2_ACTIVE, INFRARED_ACTIVE, RUNTIME_ACTIVE;
    logic        FLOPPY_DMA_IRQ_ENABLE, FLOPPY_POWERED_DOWN, SERIAL1_IRQ_GATE, SERIAL2_IRQ_GATE;
    logic        INFRARED_DMA_ENABLE, PARALLEL_IRQ_ENABLE, PARALLEL_DMA_ENABLE;
    logic        FLOPPY_IRQ_IN, FLOPPY_DRQ_IN, PARALLEL_IRQ_IN, PARALLEL_DRQ_IN;
    logic        SERIAL1_IRQ_IN, SERIAL2_IRQ_IN, INFRARED_IRQ_IN, INFRARED_DRQ_IN;
    logic        FLOPPY_IRQ, FLOPPY_DRQ, PARALLEL_IRQ, PARALLEL_DRQ;
    logic        SERIAL1_IRQ, SERIAL2_IRQ, INFRARED_IRQ, INFRARED_DRQ;
    int          n_fail = 0;
    int          total_checks = 0;
    wire  [6:0]  sels = {CFG_SEL, FLOPPY_SEL, PARALLEL_SEL, SERIAL1_SEL, SERIAL2_SEL, INFRARED_SEL, RUNTIME_SEL};
    wire  [7:0]  reqs = {FLOPPY_IRQ, FLOPPY_DRQ, PARALLEL_IRQ, PARALLEL_DRQ,
                         SERIAL1_IRQ, SERIAL2_IRQ, INFRARED_IRQ, INFRARED_DRQ};
    logic [15:0] adr [10] = '{16'h0100, 16'h0107, 16'h0108, 16'h03F8, 16'h03FF,
                              16'h0400, 16'h0110, 16'h0117, 16'h07F8, 16'h0800};
    logic [6:0]  exs [10] = '{7'h20, 7'h20, 7'h00, 7'h08, 7'h08, 7'h00, 7'h04, 7'h04, 7'h02, 7'h00};
    always #10 CLK = ~CLK;
    ldev_decode ldev_decode_i (.*);
    lpc_host_model lpc_host_model_i (.CLK, .IO_RDATA, .IO_CLAIM, .IO_ADDR, .IO_WR, .IO_RD, .IO_WDATA);
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic strap);
        @(negedge CLK);
        {RST_N, CONFIG_ADDRESS_STRAP} = {1'h0, strap};
        repeat (3) @(negedge CLK);
        RST_N = 1'h1;
        repeat (2) @(negedge CLK);
        base = strap ? 16'h004E : 16'h002E;
    endtask
    task automatic probe(input logic [15:0] a, input logic [6:0] e);
        lpc_host_model_i.put_addr(a);
        chk("selects", {9'h000, e}, {9'h000, sels});
    endtask
    task automatic psel(input logic [15:0] a, input logic [1:0] e);
        lpc_host_model_i.put_addr(a);
        chk("parallel selects", {14'h0000, e}, {14'h0000, PARALLEL_EPP_SEL, PARALLEL_ECP_SEL});
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        lpc_host_model_i.cfg(base, idx, 1'h1, d, q);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        lpc_host_model_i.cfg(base, idx, 1'h0, 8'h00, q);
        chk("config data", {8'h00, e}, {8'h00, q});
    endtask
    task automatic gate(input logic [7:0] e);
        repeat (2) @(negedge CLK);
        chk("requests", {8'h00, e}, {8'h00, reqs});
    endtask
    task automatic knock(input logic [7:0] off, input logic [7:0] e);
        {FLOPPY_DMA_IRQ_ENABLE, SERIAL1_IRQ_GATE, SERIAL2_IRQ_GATE, INFRARED_DMA_ENABLE} = ~off[7:4];
        {PARALLEL_DMA_ENABLE, PARALLEL_ACTIVE, FLOPPY_ACTIVE} = ~off[3:1];
        FLOPPY_POWERED_DOWN = off[0];
        gate(e);
    endtask
    initial begin
        {RST_N, CONFIG_ADDRESS_STRAP, base, PARALLEL_ECR_MODE} = '0;
        {FLOPPY_ACTIVE, PARALLEL_ACTIVE, SERIAL1_ACTIVE, SERIAL2_ACTIVE, INFRARED_ACTIVE, RUNTIME_ACTIVE} = 6'h3F;
        {FLOPPY_DMA_IRQ_ENABLE, FLOPPY_POWERED_DOWN, SERIAL1_IRQ_GATE, SERIAL2_IRQ_GATE} = 4'h0;
        {INFRARED_DMA_ENABLE, PARALLEL_IRQ_ENABLE, PARALLEL_DMA_ENABLE} = 3'h0;
        {FLOPPY_IRQ_IN, FLOPPY_DRQ_IN, PARALLEL_IRQ_IN, PARALLEL_DRQ_IN} = 4'hF;
        {SERIAL1_IRQ_IN, SERIAL2_IRQ_IN, INFRARED_IRQ_IN, INFRARED_DRQ_IN} = 4'hF;
        do_reset(1'h0);
        probe(16'h002F, 7'h40);
        probe(16'h004E, 7'h00);
        // second reset mid-run moves the pair by strap alone
        do_reset(1'h1);
        probe(16'h004E, 7'h40);
        probe(16'h002E, 7'h00);
        wr(8'h30, 8'h20);
        rd(8'h30, 8'h20);
        probe(16'h0200, 7'h01);
        probe(16'h020F, 7'h01);
        probe(16'h0210, 7'h00);
        wr(8'h55, 8'hA5);
        rd(8'h55, 8'h00);
        wr(8'h20, 8'h40);
        wr(8'h24, 8'hFE);
        wr(8'h25, 8'h44);
        wr(8'h2B, 8'hFF);
        foreach (adr[i])
            probe(adr[i], exs[i]);
        lpc_host_model_i.cycle(16'h0100, 1'h0, 8'h00, q);
        chk("claim", 16'h0001, {15'h0000, lpc_host_model_i.claim_seen});
        chk("read data held", 16'h0000, {8'h00, IO_RDATA});
        FLOPPY_ACTIVE = 1'h0;
        probe(16'h0100, 7'h00);
        FLOPPY_ACTIVE = 1'h1;
        wr(8'h20, 8'h41);
        probe(16'h0104, 7'h00);
        lpc_host_model_i.cycle(16'h0104, 1'h0, 8'h00, q);
        chk("claim", 16'h0000, {15'h0000, lpc_host_model_i.claim_seen});
        wr(8'h23, 8'hDF);
        probe(16'h037C, 7'h10);
        chk("epp available", 16'h0000, {15'h0000, PARALLEL_EPP_AVAILABLE});
        psel(16'h037F, 2'h0);
        wr(8'h23, 8'hDE);
        chk("epp available", 16'h0001, {15'h0000, PARALLEL_EPP_AVAILABLE});
        psel(16'h037A, 2'h0);
        psel(16'h037B, 2'h2);
        psel(16'h037F, 2'h2);
        psel(16'h0778, 2'h1);
        psel(16'h077A, 2'h1);
        psel(16'h077B, 2'h0);
        wr(8'h12, 8'h80);
        base = 16'h0080;
        wr(8'h13, 8'h01);
        base = 16'h0180;
        probe(16'h0181, 7'h40);
        probe(16'h004E, 7'h00);
        rd(8'h12, 8'h80);
        rd(8'h13, 8'h01);
        wr(8'h20, 8'h40);
        PARALLEL_IRQ_ENABLE = 1'h1;
        knock(8'h00, 8'hFF);
        knock(8'h80, 8'h3F);
        knock(8'h01, 8'h3F);
        knock(8'h40, 8'hF7);
        knock(8'h20, 8'hFB);
        knock(8'h10, 8'hFE);
        knock(8'h08, 8'hEF);
        knock(8'h04, 8'hCF);
        knock(8'h02, 8'h3F);
        {PARALLEL_IRQ_ENABLE, FLOPPY_ACTIVE} = 2'h1;
        for (int m = 0; m < 8; m++) begin
            PARALLEL_ECR_MODE = 3'(m);
            PARALLEL_DMA_ENABLE = m[0];
            gate({2'h3, m == 2 || m == 3 || m == 6, m[0], 4'hF});
        end
        PARALLEL_IRQ_ENABLE = 1'h1;
        wr(8'h23, 8'h3F);
        gate(8'hCF);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge CLK);
        n_fail++;
        summarize();
    end
endmodule
bind ldev_decode ldev_decode_asserts ldev_decode_asserts_i (.CLK, .RST_N, .IO_WR, .IO_RD, .IO_RDATA, .IO_CLAIM,
    .CFG_SEL, .FLOPPY_SEL, .PARALLEL_SEL, .PARALLEL_EPP_SEL, .SERIAL1_SEL, .SERIAL2_SEL, .INFRARED_SEL,
    .RUNTIME_SEL, .PARALLEL_EPP_AVAILABLE, .PARALLEL_ACTIVE, .FLOPPY_DMA_IRQ_ENABLE, .FLOPPY_POWERED_DOWN,
    .SERIAL1_IRQ_GATE, .SERIAL2_IRQ_GATE, .INFRARED_DMA_ENABLE, .PARALLEL_IRQ_ENABLE, .PARALLEL_DMA_ENABLE,
    .PARALLEL_ECR_MODE, .PARALLEL_IRQ_IN, .FLOPPY_IRQ, .FLOPPY_DRQ, .PARALLEL_IRQ, .PARALLEL_DRQ, .SERIAL1_IRQ,
    .SERIAL2_IRQ, .INFRARED_DRQ);
